// File: hw/acw_adc_control.sv
// digital control of the successive-approximation converter with window detector
module acw_adc_control
    import acw_pkg::*;
#(
    parameter int DIV_WIDTH  = 5,
    parameter int DATA_WIDTH = 10
) (
    input  wire logic           ref_clk,
    input  wire logic           resetn,
    input  wire acw_sfr_req_t   sfr_req,
    output logic [7:0]          sfr_rdata,
    input  wire acw_timer_ovf_t timer_ovf,
    input  wire logic           external_start_pin,
    input  wire logic [4:0]     negative_input_select,
    input  wire logic [9:0]     core_result,
    output acw_core_ctl_t       core_ctl,
    output logic                conversion_done_flag,
    output logic                window_match_flag,
    output logic                conversion_busy
);

    if (DIV_WIDTH != 5 || DATA_WIDTH != 10) begin : g_param_check
        $error("acw_adc_control: divider must be 5 bits and data 10 bits");
    end

    typedef struct packed {
        logic                 enable;
        logic                 lp_track;
        logic                 done;
        logic                 win;
        logic [2:0]           src;
        logic [DIV_WIDTH-1:0] cfg_div;
        logic                 cfg_ljust;
        logic [7:0]           res_low;
        logic [7:0]           res_high;
        logic [15:0]          gt;
        logic [15:0]          lt;
        acw_phase_t           phase;
        logic [3:0]           cnt;
        logic [DIV_WIDTH-1:0] div_cnt;
        logic [7:0]           rdata;
        acw_core_ctl_t        core;
    } acw_state_t;

    acw_state_t st_reg;
    acw_state_t st_next;
    logic       ext_level;
    logic       ext_rise;
    logic       tick_now;
    logic       trig;
    logic       finish;
    logic       busy_write;
    logic       ctl_write;
    logic [15:0] word_new;

    ////////////////////////////////////////////////////////////////////////////
    // external start pin synchroniser

    acw_pin_sync u_pin_sync (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .pin_in    (external_start_pin),
        .pin_level (ext_level),
        .pin_rise  (ext_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [15:0] acw_format(input logic [9:0] d, input logic lj);
        if (lj) begin
            return {d, 6'h00};
        end
        return {{6{d[9]}}, d};
    endfunction : acw_format

    function automatic logic acw_less(input logic [15:0] a, input logic [15:0] b, input logic sgn);
        if (sgn) begin
            return $signed(a) < $signed(b);
        end
        return a < b;
    endfunction : acw_less

    function automatic logic acw_window_hit(input logic [15:0] w, input logic [15:0] gt,
                                            input logic [15:0] lt, input logic sgn);
        logic above_gt;
        logic below_lt;
        above_gt = acw_less(gt, w, sgn);
        below_lt = acw_less(w, lt, sgn);
        if (acw_less(gt, lt, sgn)) begin
            return above_gt && below_lt;
        end
        return below_lt || above_gt;
    endfunction : acw_window_hit

    function automatic logic acw_start_hit(input logic [2:0] src, input logic bw,
                                           input acw_timer_ovf_t ovf, input logic rise);
        logic hit;
        hit = 1'b0;
        case (src)
            ACW_SRC_BUSY_WRITE: hit = bw;
            ACW_SRC_TIMER0:     hit = ovf.timer0;
            ACW_SRC_TIMER2:     hit = ovf.timer2;
            ACW_SRC_TIMER1:     hit = ovf.timer1;
            ACW_SRC_EXT_PIN:    hit = rise;
            ACW_SRC_TIMER3:     hit = ovf.timer3;
            default:            hit = 1'b0;
        endcase
        return hit;
    endfunction : acw_start_hit

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        st_next    = st_reg;
        ctl_write  = sfr_req.wr && sfr_req.addr == ACW_ADDR_CONTROL;
        busy_write = ctl_write && sfr_req.wdata[ACW_CTL_BUSY_BIT];
        trig       = acw_start_hit(st_reg.src, busy_write, timer_ovf, ext_rise);
        finish     = 1'b0;
        word_new   = acw_format(core_result, st_reg.cfg_ljust);

        // converter clock divider runs only while enabled
        tick_now = st_reg.enable && st_reg.div_cnt == st_reg.cfg_div;
        if (!st_reg.enable || tick_now) begin
            st_next.div_cnt = '0;
        end else begin
            st_next.div_cnt = st_reg.div_cnt + 1'b1;
        end

        // register writes
        if (sfr_req.wr) begin
            unique case (sfr_req.addr)
                ACW_ADDR_CONTROL: begin
                    st_next.enable   = sfr_req.wdata[ACW_CTL_ENABLE_BIT];
                    st_next.lp_track = sfr_req.wdata[ACW_CTL_LPTRACK_BIT];
                    st_next.done     = sfr_req.wdata[ACW_CTL_DONE_BIT];
                    st_next.win      = sfr_req.wdata[ACW_CTL_WIN_BIT];
                    st_next.src      = sfr_req.wdata[ACW_CTL_SRC_LSB +: 3];
                end
                ACW_ADDR_CONFIG: begin
                    st_next.cfg_div   = sfr_req.wdata[ACW_CFG_DIV_LSB +: DIV_WIDTH];
                    st_next.cfg_ljust = sfr_req.wdata[ACW_CFG_LJUST_BIT];
                end
                ACW_ADDR_RESULT_LOW:  st_next.res_low     = sfr_req.wdata;
                ACW_ADDR_RESULT_HIGH: st_next.res_high    = sfr_req.wdata;
                ACW_ADDR_GT_LOW:      st_next.gt[7:0]     = sfr_req.wdata;
                ACW_ADDR_GT_HIGH:     st_next.gt[15:8]    = sfr_req.wdata;
                ACW_ADDR_LT_LOW:      st_next.lt[7:0]     = sfr_req.wdata;
                ACW_ADDR_LT_HIGH:     st_next.lt[15:8]    = sfr_req.wdata;
                default: ;
            endcase
        end

        // conversion sequence
        if (!st_reg.enable) begin
            st_next.phase = ACW_IDLE;
            st_next.cnt   = '0;
        end else begin
            unique case (st_reg.phase)
                ACW_IDLE: begin
                    st_next.cnt = '0;
                    if (trig) begin
                        if (st_reg.lp_track && st_reg.src != ACW_SRC_EXT_PIN) begin
                            st_next.phase = ACW_TRACK;
                        end else begin
                            st_next.phase = ACW_CONVERT;
                        end
                    end
                end
                ACW_TRACK: begin
                    if (tick_now) begin
                        if (st_reg.cnt == ACW_TRACK_SAR_CLOCKS - 4'h1) begin
                            st_next.phase = ACW_CONVERT;
                            st_next.cnt   = '0;
                        end else begin
                            st_next.cnt = st_reg.cnt + 4'h1;
                        end
                    end
                end
                ACW_CONVERT: begin
                    if (tick_now) begin
                        if (st_reg.cnt == ACW_CONV_SAR_CLOCKS - 4'h1) begin
                            st_next.phase = ACW_IDLE;
                            st_next.cnt   = '0;
                            finish        = 1'b1;
                        end else begin
                            st_next.cnt = st_reg.cnt + 4'h1;
                        end
                    end
                end
            endcase
        end

        // results and sticky flags; a hardware set wins over a clear
        if (finish) begin
            st_next.res_high = word_new[15:8];
            st_next.res_low  = word_new[7:0];
            st_next.done     = 1'b1;
            if (acw_window_hit(word_new, st_reg.gt, st_reg.lt,
                               negative_input_select != ACW_NEG_INPUT_GND)) begin
                st_next.win = 1'b1;
            end
        end

        // register reads
        if (sfr_req.rd) begin
            unique case (sfr_req.addr)
                ACW_ADDR_CONTROL: st_next.rdata = {st_reg.enable, st_reg.lp_track, st_reg.done,
                                                   st_reg.phase != ACW_IDLE, st_reg.win, st_reg.src};
                ACW_ADDR_CONFIG:      st_next.rdata = {st_reg.cfg_div, st_reg.cfg_ljust, 2'b00};
                ACW_ADDR_RESULT_LOW:  st_next.rdata = st_reg.res_low;
                ACW_ADDR_RESULT_HIGH: st_next.rdata = st_reg.res_high;
                ACW_ADDR_GT_LOW:      st_next.rdata = st_reg.gt[7:0];
                ACW_ADDR_GT_HIGH:     st_next.rdata = st_reg.gt[15:8];
                ACW_ADDR_LT_LOW:      st_next.rdata = st_reg.lt[7:0];
                ACW_ADDR_LT_HIGH:     st_next.rdata = st_reg.lt[15:8];
                default:              st_next.rdata = 8'h00;
            endcase
        end

        // analog core controls follow the next state; sar_tick carries this cycle's divider tick
        st_next.core.power_on = st_next.enable;
        st_next.core.convert  = st_next.enable && st_next.phase == ACW_CONVERT;
        st_next.core.sar_tick = tick_now;
        st_next.core.track    = st_next.enable &&
                                ((!st_next.lp_track && st_next.phase == ACW_IDLE) ||
                                 st_next.phase == ACW_TRACK ||
                                 (st_next.lp_track && st_next.src == ACW_SRC_EXT_PIN &&
                                  st_next.phase == ACW_IDLE && !ext_level));
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg           <= '0;
            st_reg.phase     <= ACW_IDLE;
            st_reg.cfg_div   <= ACW_RST_CONFIG[ACW_CFG_DIV_LSB +: DIV_WIDTH];
            st_reg.cfg_ljust <= ACW_RST_CONFIG[ACW_CFG_LJUST_BIT];
            st_reg.res_low   <= ACW_RST_RESULT;
            st_reg.res_high  <= ACW_RST_RESULT;
            st_reg.gt        <= ACW_RST_GT;
            st_reg.lt        <= ACW_RST_LT;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sfr_rdata            = st_reg.rdata;
    assign core_ctl             = st_reg.core;
    assign conversion_done_flag = st_reg.done;
    assign window_match_flag    = st_reg.win;
    assign conversion_busy      = st_reg.phase != ACW_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [3:0] a_ticks;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            a_ticks <= 4'h0;
        end else if (st_reg.phase != st_next.phase) begin
            a_ticks <= 4'h0;
        end else if (tick_now) begin
            a_ticks <= a_ticks + 4'h1;
        end
    end

    a_track_three: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_reg.phase == ACW_TRACK && st_next.phase == ACW_CONVERT) |-> a_ticks == 4'h2 && tick_now)
        else $error("tracking period is not three converter clocks");

    a_convert_ten: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_reg.phase == ACW_CONVERT && st_next.phase == ACW_IDLE && st_reg.enable)
        |-> a_ticks == 4'h9 && tick_now)
        else $error("conversion is not ten converter clocks");

    a_done_on_fall: assert property (@(posedge ref_clk) disable iff (!resetn)
        ($fell(conversion_busy) && $past(st_reg.enable)) |-> conversion_done_flag)
        else $error("done flag not set when busy fell");

    a_busy_start: assert property (@(posedge ref_clk) disable iff (!resetn)
        (busy_write && st_reg.src == ACW_SRC_BUSY_WRITE && st_reg.enable && !conversion_busy)
        |=> conversion_busy)
        else $error("busy write did not start a conversion");

    a_right_just: assert property (@(posedge ref_clk) disable iff (!resetn)
        (finish && !st_reg.cfg_ljust && !sfr_req.wr)
        |=> {st_reg.res_high[1:0], st_reg.res_low} == $past(core_result) &&
            st_reg.res_high[7:2] == {6{st_reg.res_high[1]}})
        else $error("right-justified result misplaced");

    a_left_just: assert property (@(posedge ref_clk) disable iff (!resetn)
        (finish && st_reg.cfg_ljust && !sfr_req.wr)
        |=> {st_reg.res_high, st_reg.res_low[7:6]} == $past(core_result) && st_reg.res_low[5:0] == 6'h00)
        else $error("left-justified result misplaced");

    a_config_low_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        (sfr_req.rd && sfr_req.addr == ACW_ADDR_CONFIG) |=> sfr_rdata[1:0] == 2'b00)
        else $error("unused config bits read non-zero");

    a_win_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
        (window_match_flag && !ctl_write) |=> window_match_flag)
        else $error("window flag dropped without a clear");

    a_off_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
        !st_reg.enable |=> !conversion_busy && !core_ctl.convert)
        else $error("disabled converter still active");

    a_normal_track: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_reg.enable && !st_reg.lp_track && st_reg.phase == ACW_IDLE) |-> core_ctl.track && !core_ctl.convert)
        else $error("normal mode not tracking while idle");

    a_pin_track: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_reg.enable && st_reg.lp_track && st_reg.src == ACW_SRC_EXT_PIN &&
         st_reg.phase == ACW_IDLE) |-> core_ctl.track == !$past(ext_level))
        else $error("pin mode tracking does not follow the pin");

endmodule : acw_adc_control

// File: hw/acw_pkg.sv
// shared constants and carrier types for the converter control block
package acw_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // special-function register addresses
    localparam logic [7:0] ACW_ADDR_RESULT_LOW  = 8'hBD;
    localparam logic [7:0] ACW_ADDR_RESULT_HIGH = 8'hBE;
    localparam logic [7:0] ACW_ADDR_CONFIG      = 8'hBC;
    localparam logic [7:0] ACW_ADDR_CONTROL     = 8'hE8;
    localparam logic [7:0] ACW_ADDR_GT_LOW      = 8'hC3;
    localparam logic [7:0] ACW_ADDR_GT_HIGH     = 8'hC4;
    localparam logic [7:0] ACW_ADDR_LT_LOW      = 8'hC5;
    localparam logic [7:0] ACW_ADDR_LT_HIGH     = 8'hC6;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  ACW_RST_CONFIG  = 8'hF8;
    localparam logic [7:0]  ACW_RST_CONTROL = 8'h00;
    localparam logic [7:0]  ACW_RST_RESULT  = 8'h00;
    localparam logic [15:0] ACW_RST_GT      = 16'hFFFF;
    localparam logic [15:0] ACW_RST_LT      = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int ACW_CTL_ENABLE_BIT = 7;
    localparam int ACW_CTL_LPTRACK_BIT = 6;
    localparam int ACW_CTL_DONE_BIT   = 5;
    localparam int ACW_CTL_BUSY_BIT   = 4;
    localparam int ACW_CTL_WIN_BIT    = 3;
    localparam int ACW_CTL_SRC_LSB    = 0;
    localparam int ACW_CFG_DIV_LSB    = 3;
    localparam int ACW_CFG_LJUST_BIT  = 2;

    ////////////////////////////////////////////////////////////////////////////
    // start sources and negative input code for ground
    localparam logic [2:0] ACW_SRC_BUSY_WRITE = 3'h0;
    localparam logic [2:0] ACW_SRC_TIMER0     = 3'h1;
    localparam logic [2:0] ACW_SRC_TIMER2     = 3'h2;
    localparam logic [2:0] ACW_SRC_TIMER1     = 3'h3;
    localparam logic [2:0] ACW_SRC_EXT_PIN    = 3'h4;
    localparam logic [2:0] ACW_SRC_TIMER3     = 3'h5;
    localparam logic [4:0] ACW_NEG_INPUT_GND  = 5'h11;

    ////////////////////////////////////////////////////////////////////////////
    // timing in converter clocks, and clock rates in Hz
    localparam logic [3:0] ACW_TRACK_SAR_CLOCKS = 4'h3;
    localparam logic [3:0] ACW_CONV_SAR_CLOCKS  = 4'hA;
    localparam int         ACW_SYS_CLK_HZ       = 100_000_000;
    localparam int         ACW_SAR_CLK_MAX_HZ   = 3_000_000;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acw_sfr_req_t;

    typedef struct packed {
        logic timer3;
        logic timer2;
        logic timer1;
        logic timer0;
    } acw_timer_ovf_t;

    typedef struct packed {
        logic power_on;
        logic track;
        logic convert;
        logic sar_tick;
    } acw_core_ctl_t;

    typedef enum logic [1:0] {
        ACW_IDLE,
        ACW_TRACK,
        ACW_CONVERT
    } acw_phase_t;

endpackage : acw_pkg

// File: hw/acw_pin_sync.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
module acw_pin_sync
    import acw_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic pin_in,
    output logic      pin_level,
    output logic      pin_rise
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
    } acw_sync_state_t;

    acw_sync_state_t st_reg;
    acw_sync_state_t st_next;

    always_comb begin
        st_next       = st_reg;
        st_next.s1    = pin_in;
        st_next.s2    = st_reg.s1;
        st_next.s3    = st_reg.s2;
        st_next.rise  = 1'b0;
        // a change counts only once stages two and three agree
        if (st_reg.s2 == st_reg.s3) begin
            st_next.level = st_reg.s2;
            st_next.rise  = st_reg.s2 & ~st_reg.level;
        end
    end

    // idle level is high so that reset release makes no false edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1, rise: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pin_level = st_reg.level;
    assign pin_rise  = st_reg.rise;

endmodule : acw_pin_sync

// File: sim/acw_core_model.sv
// behavioural analog core that answers every conversion with a programmed code
module acw_core_model
    import acw_pkg::*;
(
    input  wire acw_core_ctl_t core_ctl,
    input  wire logic [9:0]    code,
    output logic [9:0]         core_result
);
    timeunit 1ns;
    timeprecision 1ps;
    // outside conversion the output is inverted so a stale sample shows up
    assign core_result = core_ctl.convert ? code : ~code;
endmodule : acw_core_model

// File: sim/acw_adc_control_tb.sv
// self-checking bench for the converter control block
module acw_adc_control_tb
    import acw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] DIV = 5'h01;
    logic           ref_clk;
    logic           resetn;
    logic           pin;
    acw_sfr_req_t   req;
    logic [7:0]     rdata;
    acw_timer_ovf_t ovf;
    logic [4:0]     neg;
    logic [9:0]     code;
    logic [9:0]     cres;
    acw_core_ctl_t  ctl;
    logic           done;
    logic           win;
    logic           busy;
    logic [15:0]    gt;
    logic [15:0]    lt;
    int             errors;
    int             checks;
    int             cyc;

    acw_adc_control DUT (.ref_clk(ref_clk), .resetn(resetn), .sfr_req(req), .sfr_rdata(rdata),
        .timer_ovf(ovf), .external_start_pin(pin), .negative_input_select(neg), .core_result(cres),
        .core_ctl(ctl), .conversion_done_flag(done), .window_match_flag(win), .conversion_busy(busy));
    acw_core_model core (.core_ctl(ctl), .code(code), .core_result(cres));

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // each access first lets a falling edge pass, so a strobe is never lowered and raised in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk);
        req = '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge ref_clk);
        req = '0;
        chk(rdata, e);
    endtask : rd

    task automatic setlim(input logic [15:0] g, input logic [15:0] l);
        gt = g;
        lt = l;
        wr(ACW_ADDR_GT_LOW, g[7:0]);
        wr(ACW_ADDR_GT_HIGH, g[15:8]);
        wr(ACW_ADDR_LT_LOW, l[7:0]);
        wr(ACW_ADDR_LT_HIGH, l[15:8]);
    endtask : setlim

    function automatic logic [15:0] fmt(input logic [9:0] v, input logic lj);
        return lj ? {v, 6'h00} : {{6{v[9]}}, v};
    endfunction : fmt

    function automatic logic hit(input logic [15:0] r, input logic s);
        if (s) return ($signed(lt) > $signed(gt)) ? ($signed(r) > $signed(gt) && $signed(r) < $signed(lt))
                                                  : ($signed(r) < $signed(lt) || $signed(r) > $signed(gt));
        return (lt > gt) ? (r > gt && r < lt) : (r < lt || r > gt);
    endfunction : hit

    // one full conversion from the given source, then result and flag readout
    task automatic conv(input logic [2:0] src, input logic lp, input logic [9:0] v, input logic lj);
        int          n;
        int          e;
        int          t;
        logic        lptrk;
        logic [15:0] w;
        lptrk = lp && (src != ACW_SRC_EXT_PIN);
        e = (lptrk ? 13 : 10) * (DIV + 1);
        w = fmt(v, lj);
        code = v;
        wr(ACW_ADDR_CONFIG, {DIV, lj, 2'b11});
        wr(ACW_ADDR_CONTROL, {1'b1, lp, 3'b000, src});
        chk(done, 1'b0);
        chk(win, 1'b0);
        if (!lp) chk(ctl.track, 1'b1);
        case (src)
            ACW_SRC_BUSY_WRITE: wr(ACW_ADDR_CONTROL, {1'b1, lp, 3'b010, src});
            ACW_SRC_TIMER0: ovf.timer0 = 1'b1;
            ACW_SRC_TIMER2: ovf.timer2 = 1'b1;
            ACW_SRC_TIMER1: ovf.timer1 = 1'b1;
            ACW_SRC_TIMER3: ovf.timer3 = 1'b1;
            default: begin
                repeat (6) @(negedge ref_clk);
                if (lp) chk(ctl.track, 1'b1);
                pin = 1'b1;
            end
        endcase
        if (src != ACW_SRC_BUSY_WRITE) @(negedge ref_clk);
        ovf = '0;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        chk(ctl.convert, !lptrk);
        chk(ctl.track, lptrk);
        n = 0;
        t = 0;
        // a tick seen after an edge belongs to the busy cycle before that edge
        while (busy === 1'b1 && n < 1000) begin
            @(negedge ref_clk);
            n++;
            t += ctl.sar_tick;
        end
        chk(n >= e - 2 && n <= e + 1, 1'b1);
        chk(t, lptrk ? 13 : 10);
        chk(done, 1'b1);
        rd(ACW_ADDR_RESULT_HIGH, w[15:8]);
        rd(ACW_ADDR_RESULT_LOW, w[7:0]);
        chk(win, hit(w, neg != ACW_NEG_INPUT_GND));
        chk(done, 1'b1);
        pin = 1'b0;
    endtask : conv

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            $display("[ERR] %0t run did not finish", $time);
            print_verdict();
        end
    end

    initial begin
        resetn = 1'b0;
        pin = 1'b0;
        req = '0;
        ovf = '0;
        neg = ACW_NEG_INPUT_GND;
        code = 10'h000;
        gt = ACW_RST_GT;
        lt = ACW_RST_LT;
        repeat (3) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
        rd(ACW_ADDR_CONFIG, ACW_RST_CONFIG);
        rd(ACW_ADDR_CONTROL, ACW_RST_CONTROL);
        rd(ACW_ADDR_RESULT_HIGH, ACW_RST_RESULT);
        rd(8'h10, 8'h00);
        wr(ACW_ADDR_CONFIG, 8'h0B);
        rd(ACW_ADDR_CONFIG, 8'h08);
        wr(ACW_ADDR_CONTROL, 8'h10);
        repeat (4) @(negedge ref_clk);
        chk(busy, 1'b0);
        chk(ctl.power_on, 1'b0);
        setlim(16'h0040, 16'h0080);
        conv(3'h0, 1'b0, 10'h060, 1'b0);
        conv(3'h0, 1'b0, 10'h3FF, 1'b0);
        conv(3'h0, 1'b0, 10'h061, 1'b1);
        rd(ACW_ADDR_CONFIG, {DIV, 1'b1, 2'b00});
        setlim(16'h0080, 16'h0040);
        conv(3'h0, 1'b0, 10'h020, 1'b0);
        conv(3'h0, 1'b0, 10'h0C0, 1'b1);
        neg = 5'h00;
        setlim(16'hFFFF, 16'h0040);
        conv(3'h0, 1'b0, 10'h020, 1'b0);
        conv(3'h0, 1'b0, 10'h3FF, 1'b0);
        for (int s = 1; s < 6; s++) conv(s[2:0], 1'b0, 10'h155, 1'b0);
        for (int s = 0; s < 6; s += 2) conv(s[2:0], 1'b1, 10'h2AA, 1'b1);
        wr(ACW_ADDR_CONTROL, 8'h91);
        wr(ACW_ADDR_CONTROL, 8'h86);
        ovf = 4'hF;
        pin = 1'b1;
        @(negedge ref_clk);
        ovf = '0;
        repeat (6) @(negedge ref_clk);
        chk(busy, 1'b0);
        print_verdict();
    end
endmodule : acw_adc_control_tb
